/* File: design/mxs_consts.vh */
// Purpose: constants for the extended management register slave
// Assumes: included by bare name from design files
// Notes: frame field lengths in management clock bits
`ifndef MXS_CONSTS_VH
`define MXS_CONSTS_VH
`define MXS_PREAMBLE_LEN 6'd32
`define MXS_MODE_EXT 2'b01
`define MXS_OP_READ 2'b10
`define MXS_OP_WRITE 2'b01
`define MXS_ADDR_W 10
`define MXS_DATA_W 32
`define MXS_HALF_W 16
`define MXS_SYNC_STAGES 2
`endif

/* File: design/mxs_sync.v */
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to sys_clk_i
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module mxs_sync (
    // clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // level in and out
    input wire async_i,
    output wire sync_o
);
    reg meta;
    reg stable;
    // metastability guard; reset value high matches the idle pulled-up bus
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta <= 1'b1;
            stable <= 1'b1;
        end else begin
            meta <= async_i;
            stable <= meta;
        end
    end
    assign sync_o = stable;
endmodule // mxs_sync
`default_nettype wire

/* File: design/mxs_slave.v */
// Purpose: management-pin slave giving a host 32-bit access to system registers
// Assumes: host keeps MDC at or below 2.5 MHz, far below the 250 MHz system clock
// Notes: register file lives outside; this block issues read and write strobes
`timescale 1ns/1ps
`default_nettype none
`include "mxs_consts.vh"
module mxs_slave (
    // clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // straps and device state
    input wire [1:0] mode_strap_i,
    input wire dev_reset_busy_i,
    // management pins
    input wire mdc_i,
    input wire mdio_i,
    output reg mdio_o,
    output reg mdio_oe_o,
    // register file access
    output wire [`MXS_ADDR_W-1:0] reg_addr_o,
    input wire [`MXS_DATA_W-1:0] reg_rdata_i,
    input wire reg_valid_i,
    input wire reg_half_ok_i,
    output reg reg_rd_done_o,
    output reg reg_wr_o,
    output reg [`MXS_DATA_W-1:0] reg_wdata_o
);
    // frame states; a frame walks preamble, start, header, turnaround and then one
    // of read data, write data or skip, and always falls back to preamble hunting,
    // so a host that gives up mid-frame only costs one frame before the next sync
    // frame states
    localparam ST_PRE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_HDR = 3'd2;
    localparam ST_TA = 3'd3;
    localparam ST_RDATA = 3'd4;
    localparam ST_WDATA = 3'd5;
    localparam ST_SKIP = 3'd6;

    wire mdc_s;
    wire mdio_s;
    reg mdc_q;
    reg [1:0] mode_q;
    reg [2:0] state;
    reg [5:0] cnt;
    reg [11:0] hdr;
    reg [15:0] shreg;
    reg [`MXS_ADDR_W-1:0] pair_addr;
    reg pair_open;
    reg pair_half;
    reg pair_is_rd;
    reg [`MXS_DATA_W-1:0] rd_latch;
    reg [15:0] wr_hold;
    reg busy_q;
    reg [`MXS_ADDR_W-1:0] cur_addr;
    reg cur_half;

    // header bits: op[11:10], phy[9:5], reg[4:0]
    wire [1:0] hdr_op = hdr[11:10];
    wire mdc_rise = mdc_s & ~mdc_q;
    wire ext_on = (mode_q == `MXS_MODE_EXT);
    wire hdr_mine = hdr[9] & ext_on;
    wire [`MXS_ADDR_W-1:0] hdr_addr = {hdr[8:5], hdr[4:1], 2'b00};
    // register value with unimplemented addresses forced to zero
    wire [`MXS_DATA_W-1:0] rd_word = reg_valid_i ? reg_rdata_i
        : {`MXS_DATA_W{1'b0}};

    assign reg_addr_o = cur_addr;

    // pick a 16-bit half from a 32-bit word
    function [15:0] half_of;
        input [31:0] word;
        input upper;
        begin
            half_of = upper ? word[31:16] : word[15:0];
        end
    endfunction

    // open pair is the opposite half of the same register for this kind of frame;
    // read and write pairs are kept apart so a stray write cannot finish a read
    function pair_other;
        input open;
        input open_is_rd;
        input want_rd;
        input [`MXS_ADDR_W-1:0] open_addr;
        input [`MXS_ADDR_W-1:0] now_addr;
        input open_half;
        input now_half;
        begin
            pair_other = open & (open_is_rd == want_rd) & (open_addr == now_addr)
                & (open_half != now_half);
        end
    endfunction

    // open pair holds the same half of the same kind of frame
    function pair_repeat;
        input open;
        input open_is_rd;
        input want_rd;
        input open_half;
        input now_half;
        begin
            pair_repeat = open & (open_is_rd == want_rd) & (open_half == now_half);
        end
    endfunction

    // pair decodes for the frame in flight; cur_addr and cur_half settle at the
    // first turnaround edge, one link edge before any of these is consulted
    wire rd_second = pair_other(pair_open, pair_is_rd, 1'b1, pair_addr, cur_addr,
        pair_half, cur_half);
    wire rd_repeat = pair_repeat(pair_open, pair_is_rd, 1'b1, pair_half, cur_half);
    wire wr_second = pair_other(pair_open, pair_is_rd, 1'b0, pair_addr, cur_addr,
        pair_half, cur_half);
    wire wr_repeat = pair_repeat(pair_open, pair_is_rd, 1'b0, pair_half, cur_half);

    // pin synchronisers
    mxs_sync u_sync_mdc (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i(mdc_i),
        .sync_o(mdc_s)
    );
    mxs_sync u_sync_mdio (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i(mdio_i),
        .sync_o(mdio_s)
    );

    // straps sampled every clock after release; straps are steady levels so one clocked sample will do
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            mode_q <= 2'b00;
        end else begin
            mode_q <= mode_strap_i;
        end
    end

    // edge tracking and device reset follower; mdc_q resets high so the synchroniser
    // settling from its high reset value can never look like a rising edge
    // while the device is in reset the register file shows no trustworthy data;
    // frames are still served so the host can poll for the test word
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            mdc_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            mdc_q <= mdc_s;
            busy_q <= dev_reset_busy_i;
        end
    end

    // frame engine; apart from strobe clears and the device-reset pair drop, everything advances on a synchronised MDC rising edge
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            state <= ST_PRE;
            cnt <= 6'd0;
            hdr <= 12'h000;
            shreg <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            pair_open <= 1'b0;
            pair_half <= 1'b0;
            pair_is_rd <= 1'b0;
            pair_addr <= {`MXS_ADDR_W{1'b0}};
            rd_latch <= 32'h00000000;
            wr_hold <= 16'h0000;
            cur_addr <= {`MXS_ADDR_W{1'b0}};
            cur_half <= 1'b0;
            reg_rd_done_o <= 1'b0;
            reg_wr_o <= 1'b0;
            reg_wdata_o <= 32'h00000000;
        end else begin
            reg_rd_done_o <= 1'b0;
            reg_wr_o <= 1'b0;
            // device reset finishing mid-pair drops the half-open pair
            if (busy_q & ~dev_reset_busy_i) begin
                pair_open <= 1'b0;
            end
            if (mdc_rise) begin
                case (state)
                    ST_PRE: begin
                        // count ones of the preamble; a zero after 32 is start bit 0
                        if (mdio_s) begin
                            if (cnt != `MXS_PREAMBLE_LEN) begin
                                cnt <= cnt + 6'd1;
                            end
                        end else if (cnt == `MXS_PREAMBLE_LEN) begin
                            state <= ST_START;
                        end else begin
                            cnt <= 6'd0;
                        end
                    end
                    ST_START: begin
                        // second start bit must be one
                        cnt <= 6'd0;
                        state <= mdio_s ? ST_HDR : ST_PRE;
                    end
                    ST_HDR: begin
                        hdr <= {hdr[10:0], mdio_s};
                        if (cnt == 6'd11) begin
                            cnt <= 6'd0;
                            state <= ST_TA;
                        end else begin
                            cnt <= cnt + 6'd1;
                        end
                    end
                    ST_TA: begin
                        // first turnaround edge: latch address, stay released
                        if (cnt == 6'd0) begin
                            cur_addr <= hdr_addr;
                            cur_half <= hdr[0];
                            if (!hdr_mine) begin
                                state <= ST_SKIP;
                                cnt <= 6'd0;
                            end else if (hdr_op == `MXS_OP_READ) begin
                                cnt <= 6'd1;
                            end else if (hdr_op == `MXS_OP_WRITE) begin
                                cnt <= 6'd1;
                            end else begin
                                state <= ST_SKIP;
                                cnt <= 6'd0;
                            end
                        end else if (hdr_op == `MXS_OP_READ) begin
                            // second turnaround bit driven low, data captured now
                            mdio_oe_o <= 1'b1;
                            mdio_o <= 1'b0;
                            cnt <= 6'd0;
                            state <= ST_RDATA;
                            if (rd_second) begin
                                // second half: serve the word latched at the first
                                shreg <= half_of(rd_latch, cur_half);
                            end else begin
                                // fresh capture; unused addresses come back as zero
                                rd_latch <= rd_word;
                                shreg <= half_of(rd_word, cur_half);
                            end
                        end else begin
                            // write turnaround is host driven; we stay released
                            cnt <= 6'd0;
                            state <= ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        // shift out msb first, one bit per rising edge
                        if (cnt == 6'd16) begin
                            mdio_oe_o <= 1'b0;
                            mdio_o <= 1'b0;
                            state <= ST_PRE;
                            cnt <= 6'd0;
                            if (rd_second) begin
                                // complete pair: side effects allowed now
                                pair_open <= 1'b0;
                                reg_rd_done_o <= 1'b1;
                            end else if (rd_repeat) begin
                                // same half twice: void and restart with next read
                                pair_open <= 1'b0;
                            end else if (reg_half_ok_i & reg_valid_i) begin
                                pair_open <= 1'b0;
                            end else begin
                                pair_open <= 1'b1;
                                pair_is_rd <= 1'b1;
                                pair_half <= cur_half;
                                pair_addr <= cur_addr;
                            end
                        end else begin
                            mdio_o <= shreg[15];
                            shreg <= {shreg[14:0], 1'b0};
                            cnt <= cnt + 6'd1;
                        end
                    end
                    ST_WDATA: begin
                        shreg <= {shreg[14:0], mdio_s};
                        if (cnt == 6'd15) begin
                            state <= ST_PRE;
                            cnt <= 6'd0;
                            if (wr_second) begin
                                // both halves held: commit the word in one strobe
                                reg_wr_o <= 1'b1;
                                reg_wdata_o <= cur_half ? {shreg[14:0], mdio_s, wr_hold}
                                    : {wr_hold, shreg[14:0], mdio_s};
                                pair_open <= 1'b0;
                            end else if (wr_repeat) begin
                                // repeated half: drop the transfer
                                pair_open <= 1'b0;
                            end else begin
                                wr_hold <= {shreg[14:0], mdio_s};
                                pair_open <= 1'b1;
                                pair_is_rd <= 1'b0;
                                pair_half <= cur_half;
                                pair_addr <= cur_addr;
                            end
                        end else begin
                            cnt <= cnt + 6'd1;
                        end
                    end
                    ST_SKIP: begin
                        // frame not for us (another PHY, ext mode off, or an op that is neither read nor write): sit out turnaround and data released
                        if (cnt == 6'd16) begin
                            state <= ST_PRE;
                            cnt <= 6'd0;
                        end else begin
                            cnt <= cnt + 6'd1;
                        end
                    end
                    default: begin
                        state <= ST_PRE;
                        cnt <= 6'd0;
                    end
                endcase
            end
        end
    end
endmodule // mxs_slave
`default_nettype wire

/* File: testbench/mxs_slave_sva.sv */
// Purpose: port checker for the management slave
// Assumes: link clock far slower than sys_clk_i
// Notes: bound to every mxs_slave instance
`timescale 1ns/1ps
`default_nettype none
module mxs_slave_sva (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // watched ports
    input wire logic [1:0] mode_strap_i,
    input wire logic mdc_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    input wire logic [9:0] reg_addr_o,
    input wire logic reg_valid_i,
    input wire logic reg_rd_done_o,
    input wire logic reg_wr_o
);
    logic mdc_q;
    logic [4:0] rises;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // link rises while driving: 16 data bits plus the release edge
    always_ff @(posedge sys_clk_i) begin
        mdc_q <= mdc_i;
        if (reset_i || !mdio_oe_o) rises <= 5'h00;
        else if (mdc_i && !mdc_q) rises <= rises + 5'h01;
    end
    // strobes last one cycle and never overlap a driven pin
    sequence s_pulse(x); x ##1 !x; endsequence
    sequence s_idle; !mdio_oe_o ##1 !mdio_oe_o; endsequence
    property p_strap; $rose(mdio_oe_o) |-> mode_strap_i == 2'b01; endproperty
    a_strap: assert property (p_strap) else $error("drive outside ext mode");
    property p_ta; $rose(mdio_oe_o) |-> !mdio_o; endproperty
    a_ta: assert property (p_ta) else $error("second ta bit not low");
    property p_len; $fell(mdio_oe_o) |-> rises == 5'h11; endproperty
    a_len: assert property (p_len) else $error("drive length wrong");
    property p_edge; mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |-> mdc_i; endproperty
    a_edge: assert property (p_edge) else $error("data moved off rising edge");
    property p_zero; mdio_oe_o && !reg_valid_i && !$past(reg_valid_i, 8) |-> !mdio_o; endproperty
    a_zero: assert property (p_zero) else $error("unused address not zero");
    property p_done; reg_rd_done_o |-> s_pulse(reg_rd_done_o) and s_idle; endproperty
    a_done: assert property (p_done) else $error("read done misplaced");
    property p_wr; reg_wr_o |-> s_pulse(reg_wr_o) and s_idle; endproperty
    a_wr: assert property (p_wr) else $error("write strobe misplaced");
    property p_addr; mdio_oe_o && $past(mdio_oe_o) |-> $stable(reg_addr_o)
        && reg_addr_o[1:0] == 2'b00; endproperty
    a_addr: assert property (p_addr) else $error("address moved in read");
endmodule // mxs_slave_sva
bind mxs_slave mxs_slave_sva u_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .mode_strap_i(mode_strap_i), .mdc_i(mdc_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
    .reg_addr_o(reg_addr_o), .reg_valid_i(reg_valid_i),
    .reg_rd_done_o(reg_rd_done_o), .reg_wr_o(reg_wr_o));
`default_nettype wire

/* File: testbench/mxs_host.sv */
// Purpose: management master model on the link pins
// Assumes: pin pulled high, link clock low between frames
// Notes: data moves mid-period, sampled on rising edges
`timescale 1ns/1ps
`default_nettype none
module mxs_host (
    // device drive
    input wire logic dev_d_i,
    input wire logic dev_oe_i,
    // resolved pins
    output logic mdc_o,
    output wire logic mdio_o
);
    logic hd = 1'b1;
    logic hoe = 1'b0;
    // pull-up wins when nobody drives
    assign mdio_o = dev_oe_i ? dev_d_i : (hoe ? hd : 1'b1);
    initial mdc_o = 1'b0;
    // one frame; a read gets a 65th edge so the release is seen
    task automatic frame(input logic rd, input logic [4:0] p, input logic [4:0] r,
        input logic [15:0] wd, output logic [15:0] q, output logic [1:0] ta);
        logic [63:0] v;
        v = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, p, r, 2'b10, wd};
        q = 16'h0000;
        ta = 2'h0;
        for (int i = 1; i <= (rd ? 65 : 64); i++) begin
            hoe = rd ? (i <= 46) : 1'b1;
            hd = v[63];
            v = v << 1;
            #40; // bench link pace; the slave needs only a few system clocks per half
            mdc_o = 1'b1;
            if (i == 48 || i == 49) ta = {ta[0], mdio_o};
            if (i >= 50) q = {q[14:0], mdio_o};
            #40;
            mdc_o = 1'b0;
        end
        hoe = 1'b0;
    endtask
endmodule // mxs_host
`default_nettype wire

/* File: testbench/mxs_slave_tb.sv */
// Purpose: self-checking bench for the management slave
// Assumes: register file modelled by one word regv
// Notes: random addresses and data from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module mxs_slave_tb;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] strap = 2'b01;
    logic busy = 1'b0;
    logic [31:0] regv = 32'h0;
    logic valid = 1'b1;
    logic half = 1'b0;
    wire logic mdc, mdio, dq, doe, rdd, wr;
    wire logic [9:0] addr;
    wire logic [31:0] wdat;
    logic [31:0] seed = 32'h312a;
    logic [31:0] t, w, v, wseen, aseen;
    logic [4:0] p;
    logic [15:0] q;
    int miscompares = 0, n_compared = 0, wcnt = 0, dcnt = 0, c;
    always #2 sys_clk_i = ~sys_clk_i;
    mxs_slave dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .mode_strap_i(strap),
        .dev_reset_busy_i(busy), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dq), .mdio_oe_o(doe),
        .reg_addr_o(addr), .reg_rdata_i(regv), .reg_valid_i(valid), .reg_half_ok_i(half),
        .reg_rd_done_o(rdd), .reg_wr_o(wr), .reg_wdata_o(wdat));
    mxs_host host (.dev_d_i(dq), .dev_oe_i(doe), .mdc_o(mdc), .mdio_o(mdio));
    // strobe monitor
    always @(posedge sys_clk_i) begin
        if (wr) begin
            wcnt++;
            wseen = wdat;
            aseen = {22'h0, addr};
        end
        if (rdd) dcnt++;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rst();
        @(posedge sys_clk_i);
        #1 reset_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1 reset_i = 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic drv(input logic vl, input logic h, input logic [1:0] m);
        @(posedge sys_clk_i);
        #1 valid = vl;
        half = h;
        strap = m;
    endtask
    // one frame; ok says the device should answer
    task automatic xf(input logic rd, input logic [4:0] a, input logic [4:0] r,
        input logic [15:0] wd, input logic ok, output logic [15:0] d);
        logic [1:0] ta;
        @(posedge sys_clk_i);
        #1 host.frame(rd, a, r, wd, d, ta);
        repeat (4) @(posedge sys_clk_i);
        #1 if (rd && ok) chk("turnaround", {30'h0, ta}, 32'h2);
        chk("pin_released", {31'h0, doe}, 32'h0);
    endtask
    // read pair; the register moves between halves
    task automatic rdp(input logic [3:0] r, input logic h, output logic [31:0] o);
        logic [15:0] a, b;
        xf(1'b1, p, {r, h}, 16'h0, 1'b1, a);
        regv = ~regv;
        xf(1'b1, p, {r, ~h}, 16'h0, 1'b1, b);
        o = h ? {a, b} : {b, a};
    endtask
    task automatic wrp(input logic [4:0] a, input logic [3:0] r, input logic h);
        xf(1'b0, a, {r, h}, h ? w[31:16] : w[15:0], 1'b0, q);
        xf(1'b0, a, {r, ~h}, h ? w[15:0] : w[31:16], 1'b0, q);
    endtask
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
    initial begin
        rst();
        for (int k = 0; k < 4; k++) begin
            t = rnd();
            w = rnd();
            p = {1'b1, t[3:0]};
            c = wcnt;
            wrp(p, t[7:4], t[8]);
            chk("wr_count", wcnt - c, 32'h1);
            chk("wr_data", wseen, w);
            chk("wr_addr", aseen, {22'h0, p[3:0], t[7:4], 2'b00});
            regv = w;
            c = dcnt;
            rdp(t[7:4], t[9], v);
            chk("rd_data", v, w);
            chk("rd_done", dcnt - c, 32'h1);
        end
        // same half twice voids the pair, next read starts afresh
        c = dcnt;
        xf(1'b1, p, {t[7:4], 1'b0}, 16'h0, 1'b1, q);
        xf(1'b1, p, {t[7:4], 1'b0}, 16'h0, 1'b1, q);
        chk("void_pair", dcnt - c, 32'h0);
        w = regv;
        rdp(t[7:4], 1'b0, v);
        chk("fresh_pair", v, w);
        chk("fresh_done", dcnt - c, 32'h1);
        drv(1'b1, 1'b1, 2'b01);
        w = regv;
        c = dcnt;
        xf(1'b1, p, {t[7:4], 1'b1}, 16'h0, 1'b1, q);
        drv(1'b1, 1'b0, 2'b01);
        chk("half_read", {16'h0, q}, {16'h0, w[31:16]});
        regv = rnd();
        w = regv;
        rdp(t[7:4], 1'b0, v);
        chk("half_next", v, w);
        drv(1'b0, 1'b0, 2'b01);
        rdp(t[7:4], 1'b1, v);
        chk("unused", v, 32'h0);
        drv(1'b1, 1'b0, 2'b01);
        // device reset ends between halves
        c = dcnt;
        xf(1'b1, p, {t[7:4], 1'b1}, 16'h0, 1'b1, q);
        busy = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1 busy = 1'b0;
        xf(1'b1, p, {t[7:4], 1'b0}, 16'h0, 1'b1, q);
        chk("reset_pair", dcnt - c, 32'h0);
        xf(1'b1, p, {t[7:4], 1'b1}, 16'h0, 1'b1, q);
        chk("reset_next", dcnt - c, 32'h1);
        // host polls the test word with single reads until reset is over
        drv(1'b1, 1'b1, 2'b01);
        busy = 1'b1;
        regv = 32'h0;
        c = 0;
        q = 16'h0;
        while (c < 4 && q !== 16'h5a3c) begin
            xf(1'b1, p, {t[7:4], 1'b1}, 16'h0, 1'b1, q);
            c++;
            if (c == 2) begin
                busy = 1'b0;
                regv = 32'h5a3c0000;
            end
        end
        chk("poll_word", {16'h0, q}, 32'h5a3c);
        chk("poll_tries", c, 32'h3);
        drv(1'b1, 1'b0, 2'b01);
        c = wcnt;
        xf(1'b0, p, {t[7:4], 1'b1}, 16'h0, 1'b0, q);
        xf(1'b0, p, {t[7:4], 1'b1}, 16'h0, 1'b0, q);
        chk("same_half_wr", wcnt - c, 32'h0);
        rst();
        xf(1'b1, {1'b0, p[3:0]}, {t[7:4], 1'b1}, 16'h0, 1'b0, q);
        chk("low_phy_rd", {16'h0, q}, 32'hffff);
        wrp({1'b0, p[3:0]}, t[7:4], 1'b0);
        chk("low_phy_wr", wcnt - c, 32'h0);
        for (int m = 0; m < 4; m++) begin
            if (m != 1) begin
                drv(1'b1, 1'b0, m[1:0]);
                xf(1'b1, p, {t[7:4], 1'b1}, 16'h0, 1'b0, q);
                chk("strap_off", {16'h0, q}, 32'hffff);
            end
        end
        end_of_test();
    end
endmodule // mxs_slave_tb
`default_nettype wire
